//--- pkg/bt1pc_map.svh
`ifndef BT1PC_MAP_SVH
`define BT1PC_MAP_SVH

// register indices; byte address is four times the index
`define BT1PC_IDX_ABILITY 14'h0012
`define BT1PC_IDX_CONTROL 14'h0834
`define BT1PC_IDX_PMA 14'h08f6
`define BT1PC_ADDR_W 16

// reset and constant values
`define BT1PC_ABILITY_VAL 16'h0004
`define BT1PC_CTRL_RST 16'h8002
`define BT1PC_PMA_RST 16'h0000
`define BT1PC_TYPE_LONG 4'h2

// field positions
`define BT1PC_CTRL_RSV15 15
`define BT1PC_CTRL_ROLE 14
`define BT1PC_PMA_SC15 15
`define BT1PC_PMA_TXDIS 14
`define BT1PC_PMA_AMP 12
`define BT1PC_PMA_RSV11 11
`define BT1PC_PMA_EEE 10
`define BT1PC_PMA_LB 0

// strap settling cycles after reset release
`define BT1PC_STRAP_SETTLE 2'h3

// bus responses
`define BT1PC_RESP_OKAY 2'h0
`define BT1PC_RESP_SLVERR 2'h2

`endif

//--- pkg/bt1pc_pkg.sv
package bt1pc_pkg;

    // outcome of the autonegotiation logic and forced-mode selection
    typedef struct packed {
        logic an_enable;
        logic forced_cfg;
        logic an_master;
        logic [3:0] an_phy_type;
        logic an_amp_high;
    } bt1pc_an_t;

    // settings the pma actually runs with
    typedef struct packed {
        logic master;
        logic [3:0] phy_type;
        logic tx_enable;
        logic amp_high;
        logic eee_enable;
        logic loopback;
    } bt1pc_cfg_t;

endpackage

//--- design/bt1pc_regs.sv
`timescale 1ns/1ns
`include "bt1pc_map.svh"
// Overview of operation
// - ability register is read only; writes change nothing and have no side effect
// - ability bit 2 reads 1, long-reach support, so the word is constant
// - ability bits 3, 1, 0 and reserved 15:4 always read 0
// - control resets to 0xc002 on the first port, 0x8002 on the second; bit 15 fixed 1, role 1 first port, 0 second
// - role_select 1 makes the phy master, 0 makes it slave
// - role_select applies only with autonegotiation off; otherwise negotiated role
// - phy_type_select codes 0010/0011/0000, resets to 0x2, software writes 0010 only; the register stores any 4-bit code written
// - phy_type_select applies only with autonegotiation off and forced config on
// - tx_output_disable 1 suppresses transmit output, 0 enables it
// - tx_amplitude_high picks 2.4 V or 1.0 V, reset from strap pin
// - amplitude bit applies only with autonegotiation off; otherwise negotiated level
// - pma_local_loopback returns transmit data on receive path
module bt1pc_regs #(
    parameter int DATA_W = 8,
    parameter bit SECOND_PORT = 1'b0
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [`BT1PC_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [`BT1PC_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // autonegotiation outcome
    input wire bt1pc_pkg::bt1pc_an_t an_in,
    // amplitude strap pin
    input wire logic amp_strap_pin,
    // pma data path
    input wire logic [DATA_W-1:0] tx_data_in,
    input wire logic tx_valid_in,
    input wire logic [DATA_W-1:0] line_rx_data,
    input wire logic line_rx_valid,
    output logic [DATA_W-1:0] line_tx_data,
    output logic line_tx_valid,
    output logic [DATA_W-1:0] rx_data_out,
    output logic rx_valid_out,
    // effective pma settings
    output bt1pc_pkg::bt1pc_cfg_t cfg_out
);

    typedef struct packed {
        logic [2:0] strap_sync;
        logic [1:0] settle_cnt;
        logic strap_done;
        logic aw_ok;
        logic [13:0] aw_idx;
        logic w_ok;
        logic [15:0] w_data;
        logic [1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [15:0] rdata;
        logic [1:0] rresp;
        logic role;
        logic [3:0] phy_type;
        logic txdis;
        logic amp;
        logic sc15;
        logic rsv11;
        logic eee;
        logic lb;
        bt1pc_pkg::bt1pc_cfg_t cfg;
        logic [DATA_W-1:0] tx_data;
        logic tx_valid;
        logic [DATA_W-1:0] rx_data;
        logic rx_valid;
    } bt1pc_state_t;

    bt1pc_state_t s_ff;
    bt1pc_state_t nxt_s;
    bt1pc_state_t rst_s;

    logic [15:0] ctrl_word;
    logic [15:0] pma_word;
    logic [15:0] merged;
    logic [15:0] cur_word;
    logic wr_fire;
    logic ar_fire;
    logic [13:0] ar_idx;

    // read-only bits are constants in the assembled words
    assign ctrl_word = {1'b1, s_ff.role, 10'h000, s_ff.phy_type};
    assign pma_word = {s_ff.sc15, s_ff.txdis, 1'b0, s_ff.amp, s_ff.rsv11, s_ff.eee,
        9'h000, s_ff.lb};

    assign awready = !s_ff.aw_ok && !s_ff.bvalid && s_ff.strap_done;
    assign wready = !s_ff.w_ok && !s_ff.bvalid && s_ff.strap_done;
    assign arready = !s_ff.rvalid && s_ff.strap_done;
    assign wr_fire = s_ff.aw_ok && s_ff.w_ok && !s_ff.bvalid;
    assign ar_fire = arvalid && arready;
    assign ar_idx = araddr[`BT1PC_ADDR_W-1:2];

    assign bvalid = s_ff.bvalid;
    assign bresp = s_ff.bresp;
    assign rvalid = s_ff.rvalid;
    assign rresp = s_ff.rresp;
    assign rdata = {16'h0000, s_ff.rdata};
    assign line_tx_data = s_ff.tx_data;
    assign line_tx_valid = s_ff.tx_valid;
    assign rx_data_out = s_ff.rx_data;
    assign rx_valid_out = s_ff.rx_valid;
    assign cfg_out = s_ff.cfg;

    always_comb begin
        rst_s = '0;
        rst_s.role = ~SECOND_PORT;
        rst_s.phy_type = `BT1PC_TYPE_LONG;
        rst_s.bresp = `BT1PC_RESP_OKAY;
        rst_s.rresp = `BT1PC_RESP_OKAY;
    end

    // word currently held by the addressed writable register
    always_comb begin
        case (s_ff.aw_idx)
            `BT1PC_IDX_CONTROL: cur_word = ctrl_word;
            `BT1PC_IDX_PMA: cur_word = pma_word;
            default: cur_word = 16'h0000;
        endcase
        merged[7:0] = s_ff.w_strb[0] ? s_ff.w_data[7:0] : cur_word[7:0];
        merged[15:8] = s_ff.w_strb[1] ? s_ff.w_data[15:8] : cur_word[15:8];
    end

    always_comb begin
        nxt_s = s_ff;
        // self-clearing reserved bit lasts one cycle
        nxt_s.sc15 = 1'b0;

        // strap pin through three flops; taken after the settle count once stages two and three agree
        nxt_s.strap_sync = {s_ff.strap_sync[1:0], amp_strap_pin};
        if (!s_ff.strap_done) begin
            if (s_ff.settle_cnt != `BT1PC_STRAP_SETTLE) begin
                nxt_s.settle_cnt = s_ff.settle_cnt + 2'h1;
            end else if (s_ff.strap_sync[1] == s_ff.strap_sync[2]) begin
                nxt_s.amp = s_ff.strap_sync[2];
                nxt_s.strap_done = 1'b1;
            end
        end

        // write address and data, in either order
        if (awvalid && awready) begin
            nxt_s.aw_ok = 1'b1;
            nxt_s.aw_idx = awaddr[`BT1PC_ADDR_W-1:2];
        end
        if (wvalid && wready) begin
            nxt_s.w_ok = 1'b1;
            nxt_s.w_data = wdata[15:0];
            nxt_s.w_strb = wstrb[1:0];
        end

        if (wr_fire) begin
            nxt_s.aw_ok = 1'b0;
            nxt_s.w_ok = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = `BT1PC_RESP_OKAY;
            case (s_ff.aw_idx)
                `BT1PC_IDX_ABILITY: begin
                    // accepted, nothing stored
                    nxt_s.bresp = `BT1PC_RESP_OKAY;
                end
                `BT1PC_IDX_CONTROL: begin
                    nxt_s.role = merged[`BT1PC_CTRL_ROLE];
                    nxt_s.phy_type = merged[3:0];
                end
                `BT1PC_IDX_PMA: begin
                    nxt_s.sc15 = merged[`BT1PC_PMA_SC15];
                    nxt_s.txdis = merged[`BT1PC_PMA_TXDIS];
                    nxt_s.amp = merged[`BT1PC_PMA_AMP];
                    nxt_s.rsv11 = merged[`BT1PC_PMA_RSV11];
                    nxt_s.eee = merged[`BT1PC_PMA_EEE];
                    nxt_s.lb = merged[`BT1PC_PMA_LB];
                end
                default: begin
                    nxt_s.bresp = `BT1PC_RESP_SLVERR;
                end
            endcase
        end else if (s_ff.bvalid && bready) begin
            nxt_s.bvalid = 1'b0;
        end

        if (ar_fire) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = `BT1PC_RESP_OKAY;
            case (ar_idx)
                `BT1PC_IDX_ABILITY: nxt_s.rdata = `BT1PC_ABILITY_VAL;
                `BT1PC_IDX_CONTROL: nxt_s.rdata = ctrl_word;
                `BT1PC_IDX_PMA: nxt_s.rdata = pma_word;
                default: begin
                    nxt_s.rdata = 16'h0000;
                    nxt_s.rresp = `BT1PC_RESP_SLVERR;
                end
            endcase
        end else if (s_ff.rvalid && rready) begin
            nxt_s.rvalid = 1'b0;
        end

        // effective settings
        nxt_s.cfg.master = an_in.an_enable ? an_in.an_master : s_ff.role;
        if (!an_in.an_enable && an_in.forced_cfg) begin
            nxt_s.cfg.phy_type = s_ff.phy_type;
        end else begin
            nxt_s.cfg.phy_type = an_in.an_phy_type;
        end
        nxt_s.cfg.amp_high = an_in.an_enable ? an_in.an_amp_high : s_ff.amp;
        nxt_s.cfg.tx_enable = !s_ff.txdis;
        nxt_s.cfg.eee_enable = s_ff.eee;
        nxt_s.cfg.loopback = s_ff.lb;

        // transmit gate and loopback path
        nxt_s.tx_valid = tx_valid_in && !s_ff.txdis;
        nxt_s.tx_data = s_ff.txdis ? '0 : tx_data_in;
        if (s_ff.lb) begin
            nxt_s.rx_data = tx_data_in;
            nxt_s.rx_valid = tx_valid_in;
        end else begin
            nxt_s.rx_data = line_rx_data;
            nxt_s.rx_valid = line_rx_valid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= rst_s;
        end else begin
            s_ff <= nxt_s;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence rd_ability_s;
        ar_fire && ar_idx == `BT1PC_IDX_ABILITY;
    endsequence

    sequence rd_pma_s;
        ar_fire && ar_idx == `BT1PC_IDX_PMA;
    endsequence

    sequence rd_ctrl_s;
        ar_fire && ar_idx == `BT1PC_IDX_CONTROL;
    endsequence

    sequence wr_ability_s;
        wr_fire && s_ff.aw_idx == `BT1PC_IDX_ABILITY;
    endsequence

    ability_write_ro_a: assert property (
        wr_ability_s |=> $stable(ctrl_word) && $stable(pma_word[14:0]) && bvalid)
        else $error("write to ability register changed state");

    ability_bit_set_a: assert property (
        rd_ability_s |=> rvalid && rdata[2] && rresp == `BT1PC_RESP_OKAY)
        else $error("ability bit 2 not read as one");

    ability_zero_bits_a: assert property (
        rd_ability_s |=> rdata[31:3] == 29'h0 && rdata[1:0] == 2'h0)
        else $error("ability zero bits read nonzero");

    ctrl_reset_value_a: assert property (
        $rose(aresetn) |-> ctrl_word == (`BT1PC_CTRL_RST | {1'b0, ~SECOND_PORT, 14'h0000}))
        else $error("control register reset value wrong");

    role_forced_a: assert property (
        aresetn && !an_in.an_enable |=> cfg_out.master == $past(s_ff.role))
        else $error("forced role not applied");

    role_negotiated_a: assert property (
        an_in.an_enable |=> cfg_out.master == $past(an_in.an_master))
        else $error("negotiated role not applied");

    type_write_a: assert property (
        wr_fire && s_ff.aw_idx == `BT1PC_IDX_CONTROL && s_ff.w_strb[0]
        |=> s_ff.phy_type == $past(s_ff.w_data[3:0]))
        else $error("phy type field not stored");

    type_select_a: assert property (
        !an_in.an_enable && an_in.forced_cfg |=> cfg_out.phy_type == $past(s_ff.phy_type))
        else $error("forced phy type not applied");

    tx_gate_a: assert property (
        s_ff.txdis |=> !line_tx_valid && cfg_out.tx_enable == 1'b0)
        else $error("transmit output not suppressed");

    amp_strap_a: assert property (
        $rose(s_ff.strap_done) |-> s_ff.amp == $past(s_ff.strap_sync[2]))
        else $error("amplitude not loaded from strap");

    amp_select_a: assert property (
        !an_in.an_enable |=> cfg_out.amp_high == $past(s_ff.amp))
        else $error("forced amplitude not applied");

    loopback_path_a: assert property (
        s_ff.lb && tx_valid_in |=> rx_valid_out && rx_data_out == $past(tx_data_in))
        else $error("loopback data not returned");

    reserved_read_a: assert property (
        rd_pma_s |=> rdata[31:16] == 16'h0 && rdata[13] == 1'b0 && rdata[9:1] == 9'h0)
        else $error("reserved pma bits read nonzero");

    ctrl_read_fixed_a: assert property (
        rd_ctrl_s |=> rvalid && rdata[15] && rdata[13:4] == 10'h000)
        else $error("control fixed bits read wrong");

    ability_wr_okay_a: assert property (
        wr_ability_s |=> bvalid && bresp == `BT1PC_RESP_OKAY)
        else $error("write to ability register not acknowledged");

    tx_pass_a: assert property (
        aresetn && !s_ff.txdis && tx_valid_in
        |=> line_tx_valid && line_tx_data == $past(tx_data_in))
        else $error("transmit data not passed");

    loopback_off_a: assert property (
        aresetn && !s_ff.lb
        |=> rx_valid_out == $past(line_rx_valid) && rx_data_out == $past(line_rx_data))
        else $error("line receive data not passed");

    amp_negotiated_a: assert property (
        aresetn && an_in.an_enable |=> cfg_out.amp_high == $past(an_in.an_amp_high))
        else $error("negotiated amplitude not applied");

    type_negotiated_a: assert property (
        aresetn && (an_in.an_enable || !an_in.forced_cfg)
        |=> cfg_out.phy_type == $past(an_in.an_phy_type))
        else $error("negotiated phy type not applied");

endmodule

//--- tb/bt1pc_regs_tb.sv
`timescale 1ns/1ns
`include "bt1pc_map.svh"
module bt1pc_regs_tb;
    localparam logic [15:0] A_AB = {`BT1PC_IDX_ABILITY, 2'b00};
    localparam logic [15:0] A_CT = {`BT1PC_IDX_CONTROL, 2'b00};
    localparam logic [15:0] A_PM = {`BT1PC_IDX_PMA, 2'b00};
    localparam logic [1:0] OK = `BT1PC_RESP_OKAY;
    localparam logic [1:0] ERR = `BT1PC_RESP_SLVERR;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] awaddr = 16'h0;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b1;
    logic [15:0] araddr = 16'h0;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b1;
    bt1pc_pkg::bt1pc_an_t an_in = 8'h06;
    logic amp_strap_pin = 1'b1;
    logic [7:0] tx_data_in = 8'h5a;
    logic tx_valid_in = 1'b1;
    logic [7:0] line_rx_data = 8'hc3;
    logic line_rx_valid = 1'b1;
    logic [7:0] line_tx_data;
    logic line_tx_valid;
    logic [7:0] rx_data_out;
    logic rx_valid_out;
    bt1pc_pkg::bt1pc_cfg_t cfg_out;
    int n_fail = 0;
    int checked = 0;

    bt1pc_regs #(.DATA_W(8), .SECOND_PORT(1'b1)) DUT (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .an_in(an_in), .amp_strap_pin(amp_strap_pin),
        .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in),
        .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid),
        .line_tx_data(line_tx_data), .line_tx_valid(line_tx_valid),
        .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
        .cfg_out(cfg_out)
    );

    always #10 aclk = ~aclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // both channels offered together, each released once taken
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {16'h0, d};
        wstrb <= s;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    // let settings propagate, then compare the whole settings word
    task automatic cfg(input logic [8:0] e);
        repeat (3) @(posedge aclk);
        chk({23'h0, cfg_out}, {23'h0, e});
    endtask

    initial begin
        #100000;
        n_fail++;
        summarize();
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // an off, forced off, negotiated type 3
        rd(A_AB, 32'h0004, OK);
        rd(A_CT, 32'h8002, OK);
        rd(A_PM, 32'h1000, OK);
        cfg({1'b0, 4'h3, 1'b1, 1'b1, 1'b0, 1'b0});
        $display("test 1 done");
        wr(A_AB, 16'hffff, 4'h3, OK);
        rd(A_AB, 32'h0004, OK);
        $display("test 2 done");
        // fixed bits written opposite, type code kept legal
        wr(A_CT, 16'h7ff2, 4'h3, OK);
        rd(A_CT, 32'hc002, OK);
        wr(A_CT, 16'h4002, 4'h3, OK);
        an_in <= 8'h46;
        cfg({1'b1, 4'h2, 1'b1, 1'b1, 1'b0, 1'b0});
        an_in <= 8'hc6;
        cfg({1'b0, 4'h3, 1'b1, 1'b0, 1'b0, 1'b0});
        an_in <= 8'h06;
        cfg({1'b1, 4'h3, 1'b1, 1'b1, 1'b0, 1'b0});
        $display("test 3 done");
        wr(A_PM, 16'hffff, 4'h3, OK);
        rd(A_PM, 32'h5c01, OK);
        cfg({1'b1, 4'h3, 1'b0, 1'b1, 1'b1, 1'b1});
        chk({23'h0, line_tx_valid, line_tx_data}, 32'h0);
        chk({23'h0, rx_valid_out, rx_data_out}, 32'h15a);
        $display("test 4 done");
        wr(A_PM, 16'h0000, 4'h1, OK);
        rd(A_PM, 32'h5c00, OK);
        wr(A_PM, 16'h0000, 4'h3, OK);
        rd(A_PM, 32'h0000, OK);
        cfg({1'b1, 4'h3, 1'b1, 1'b0, 1'b0, 1'b0});
        chk({23'h0, line_tx_valid, line_tx_data}, 32'h15a);
        chk({23'h0, rx_valid_out, rx_data_out}, 32'h1c3);
        $display("test 5 done");
        wr(16'h0000, 16'hffff, 4'h3, ERR);
        rd(16'h0000, 32'h0, ERR);
        rd(A_CT, 32'hc002, OK);
        $display("test 6 done");
        summarize();
    end
endmodule
